// ==== socket_dma_config_regs.sv ====
// Socket DMA configuration registers: request-pin select and distributed DMA window control.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// R1: Pin select bits 31..2 read zero.
// R2: Two-bit code picks the card request pin.
// R3: Window register bits 31..16 read zero.
// R4: Bits 15..4 hold the writable window base.
// R5: Window address upper half is always zero.
// R6: Window aligned to 16 bytes, low four bits not decoded.
// R7: Extended addressing bit reads zero, ignores writes.
// R8: Width code: 8-bit, 16-bit, two reserved.
// R9: Bit 0 enables window decoding.
// R10: No 32-bit transfers; 16 bits widest.
// R11: Claim only matching base with zero upper half.
// R12: Fixed bits discard writes, read fixed values.
module socket_dma_config_regs #(
   parameter int IO_ADDR_W = socket_dma_pkg::IO_ADDR_W
) (
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic                     cfg_wr,
   input  wire logic                     cfg_rd,
   input  wire logic [7:0]               cfg_addr,
   input  wire logic [3:0]               cfg_be,
   input  wire logic [31:0]              cfg_wdata,
   output logic      [31:0]              cfg_rdata,
   output logic                          cfg_rvalid,
   input  wire socket_dma_pkg::card_pins_t card_pins,
   output logic                          dma_request,
   output logic      [1:0]               transfer_width,
   output logic                          wide_transfer,
   output logic      [15:0]              window_base,
   output logic                          decode_enabled,
   input  wire logic [IO_ADDR_W-1:0]     io_addr,
   input  wire logic                     io_valid,
   output logic                          io_hit
);

   socket_dma_pkg::state_t state_r;
   socket_dma_pkg::state_t state_nxt;

   // Read image of the request-pin select register; everything above the field is zero.
   function automatic logic [31:0] pin_image(input socket_dma_pkg::regs_t r);
      logic [31:0] v;
      v = '0;                                                                         // [R1]
      v[socket_dma_pkg::PIN_SEL_LSB +: socket_dma_pkg::PIN_SEL_W] = r.request_pin_select;
      return v;
   endfunction

   // Read image of the window control register with its hardwired bits.
   function automatic logic [31:0] window_image(input socket_dma_pkg::regs_t r);
      logic [31:0] v;
      v = '0;                                                                         // [R3] [R12]
      v[socket_dma_pkg::BASE_LSB +: socket_dma_pkg::BASE_W]   = r.window_base_field;
      v[socket_dma_pkg::EXT_ADDR_BIT]                          = socket_dma_pkg::EXT_ADDR_VALUE; // [R7]
      v[socket_dma_pkg::WIDTH_LSB +: socket_dma_pkg::WIDTH_W] = r.transfer_width_field;
      v[socket_dma_pkg::DECODE_EN_BIT]                         = r.window_decode_enable;
      return v;
   endfunction

   // Request routing: the chosen card pin is sampled into a flip-flop, none selected gives a quiet request.
   function automatic logic pick_pin(input logic [1:0] sel, input socket_dma_pkg::card_pins_t p);
      logic v;
      v = 1'b0;
      unique case (socket_dma_pkg::req_pin_t'(sel))                                   // [R2]
         socket_dma_pkg::PIN_NONE:   v = 1'b0;
         socket_dma_pkg::PIN_SPKR:   v = p.spkr;
         socket_dma_pkg::PIN_IOIS16: v = p.iois16;
         socket_dma_pkg::PIN_INPACK: v = p.inpack;
      endcase
      return v;
   endfunction

   // Next-state logic: byte-lane writes to the writable fields, a registered read answer and the request sample.
   always_comb begin
      state_nxt = state_r;
      state_nxt.rvalid = cfg_rd;
      if (cfg_rd) begin
         if (cfg_addr == socket_dma_pkg::REQ_PIN_OFFSET) begin
            state_nxt.rdata = pin_image(state_r.regs);
         end else if (cfg_addr == socket_dma_pkg::WINDOW_OFFSET) begin
            state_nxt.rdata = window_image(state_r.regs);
         end else begin
            state_nxt.rdata = '0;
         end
      end
      if (cfg_wr && (cfg_addr == socket_dma_pkg::REQ_PIN_OFFSET) && cfg_be[0]) begin
         // Only the two low bits are stored; the rest of the word is dropped.
         state_nxt.regs.request_pin_select = cfg_wdata[1:0];                           // [R1] [R12]
      end
      if (cfg_wr && (cfg_addr == socket_dma_pkg::WINDOW_OFFSET)) begin
         if (cfg_be[0]) begin
            // Bit 3 is not stored at all, so it can never read back as one.
            state_nxt.regs.window_base_field[3:0]  = cfg_wdata[7:4];                    // [R4] [R7]
            state_nxt.regs.transfer_width_field    = cfg_wdata[2:1];                    // [R8]
            state_nxt.regs.window_decode_enable    = cfg_wdata[0];                      // [R9]
         end
         if (cfg_be[1]) begin
            state_nxt.regs.window_base_field[11:4] = cfg_wdata[15:8];                   // [R4]
         end
         // Lanes 2 and 3 carry only reserved bits and are ignored.
      end
      state_nxt.dma_request = pick_pin(state_r.regs.request_pin_select, card_pins);    // [R2]
   end

   // State register with synchronous reset to the documented defaults.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r.regs.request_pin_select   <= socket_dma_pkg::PIN_SEL_RESET;
         state_r.regs.window_base_field    <= socket_dma_pkg::BASE_RESET;
         state_r.regs.transfer_width_field <= socket_dma_pkg::WIDTH_RESET;
         state_r.regs.window_decode_enable <= socket_dma_pkg::DECODE_EN_RESET;
         state_r.rdata                     <= socket_dma_pkg::RDATA_RESET;
         state_r.rvalid                    <= 1'b0;
         state_r.dma_request               <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Window decode of incoming I/O cycles; kept combinational so the claim lands in the address phase.
   dma_window_decoder #(
      .ADDR_W (IO_ADDR_W)
   ) u_decoder (
      .io_addr  (io_addr),
      .io_valid (io_valid),
      .base     (state_r.regs.window_base_field),
      .enable   (state_r.regs.window_decode_enable),                                   // [R9]
      .hit      (io_hit)
   );

   // Outputs come straight from the state register.
   assign cfg_rdata      = state_r.rdata;
   assign cfg_rvalid     = state_r.rvalid;
   assign dma_request    = state_r.dma_request;
   assign transfer_width = state_r.regs.transfer_width_field;
   assign decode_enabled = state_r.regs.window_decode_enable;
   // Reserved width codes fall back to byte transfers; nothing wider than 16 bits exists.
   assign wide_transfer  = (state_r.regs.transfer_width_field == socket_dma_pkg::WIDTH_16); // [R8] [R10]
   // The base is presented as a full 16-bit address with the low nibble hardwired to zero.
   assign window_base    = {state_r.regs.window_base_field, 4'h0};                    // [R5] [R6]

   // Checks on readback, decode and routing.

   sequence s_read_pin;
      cfg_rd && (cfg_addr == socket_dma_pkg::REQ_PIN_OFFSET);
   endsequence

   sequence s_read_win;
      cfg_rd && (cfg_addr == socket_dma_pkg::WINDOW_OFFSET);
   endsequence

   sequence s_full_write_win;
      cfg_wr && (cfg_addr == socket_dma_pkg::WINDOW_OFFSET) && (cfg_be[1:0] == 2'h3);
   endsequence

   property p_pin_upper_zero;
      @(posedge clk) disable iff (srst)
      s_read_pin |=> cfg_rvalid && (cfg_rdata[31:2] == 30'h0000_0000);
   endproperty
   a_pin_upper_zero: assert property (p_pin_upper_zero) else $error("pin select upper bits not zero"); // [R1]

   property p_request_route;
      @(posedge clk) disable iff (srst)
      $stable(state_r.regs.request_pin_select) |=>
         dma_request == ((($past(state_r.regs.request_pin_select) == 2'h1) && $past(card_pins.spkr))
                      || (($past(state_r.regs.request_pin_select) == 2'h2) && $past(card_pins.iois16))
                      || (($past(state_r.regs.request_pin_select) == 2'h3) && $past(card_pins.inpack)));
   endproperty
   a_request_route: assert property (p_request_route) else $error("request pin routed wrongly"); // [R2]

   property p_win_upper_zero;
      @(posedge clk) disable iff (srst)
      s_read_win |=> cfg_rvalid && (cfg_rdata[31:16] == 16'h0000);
   endproperty
   a_win_upper_zero: assert property (p_win_upper_zero) else $error("window upper bits not zero"); // [R3]

   property p_base_write;
      @(posedge clk) disable iff (srst)
      s_full_write_win ##1 s_read_win |=> cfg_rdata[15:4] == $past(cfg_wdata[15:4], 2);
   endproperty
   a_base_write: assert property (p_base_write) else $error("window base did not take write"); // [R4]

   property p_hit_low_64k;
      @(posedge clk) disable iff (srst)
      io_hit |-> (io_addr[IO_ADDR_W-1:socket_dma_pkg::WIN_UPPER_LSB] == '0);
   endproperty
   a_hit_low_64k: assert property (p_hit_low_64k) else $error("claim outside low 64K"); // [R5]

   property p_hit_base;
      @(posedge clk) disable iff (srst)
      io_hit |-> (io_addr[15:4] == window_base[15:4]) && decode_enabled;
   endproperty
   a_hit_base: assert property (p_hit_base) else $error("claim off programmed base"); // [R6]

   property p_ext_zero;
      @(posedge clk) disable iff (srst)
      s_full_write_win ##1 s_read_win |=> cfg_rdata[3] == 1'b0;
   endproperty
   a_ext_zero: assert property (p_ext_zero) else $error("extended addressing bit read as one"); // [R7]

   property p_width_map;
      @(posedge clk) disable iff (srst)
      wide_transfer |-> (transfer_width == 2'h1);
   endproperty
   a_width_map: assert property (p_width_map) else $error("wide transfer with non-16-bit code"); // [R8]

   property p_decode_gate;
      @(posedge clk) disable iff (srst)
      (io_valid && decode_enabled && (io_addr[IO_ADDR_W-1:4] == {{(IO_ADDR_W-16){1'b0}}, window_base[15:4]}))
         |-> io_hit;
   endproperty
   a_decode_gate: assert property (p_decode_gate) else $error("matching access not claimed"); // [R9]

   property p_no_claim_disabled;
      @(posedge clk) disable iff (srst)
      !decode_enabled |-> !io_hit;
   endproperty
   a_no_claim_disabled: assert property (p_no_claim_disabled) else $error("claim while decode off"); // [R11]

   property p_pin_write;
      @(posedge clk) disable iff (srst)
      (cfg_wr && (cfg_addr == socket_dma_pkg::REQ_PIN_OFFSET) && cfg_be[0]) ##1 s_read_pin
         |=> cfg_rdata == {30'h0000_0000, $past(cfg_wdata[1:0], 2)};
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("pin select write not kept or leaked"); // [R12]

   property p_no_wide32;
      @(posedge clk) disable iff (srst)
      transfer_width[1] |-> !wide_transfer;
   endproperty
   a_no_wide32: assert property (p_no_wide32) else $error("reserved width treated as wide"); // [R10]

endmodule : socket_dma_config_regs
`default_nettype wire

// ==== socket_dma_pkg.sv ====
// Package with the offsets, field layouts, encodings and state types of the socket DMA configuration registers.
package socket_dma_pkg;

   // Configuration-space byte offsets of the two registers.
   localparam logic [7:0]  REQ_PIN_OFFSET      = 8'h94;
   localparam logic [7:0]  WINDOW_OFFSET       = 8'h98;

   // Field positions in the request-pin select register.
   localparam int          PIN_SEL_LSB         = 0;
   localparam int          PIN_SEL_W           = 2;

   // Field positions in the window control register.
   localparam int          DECODE_EN_BIT       = 0;
   localparam int          WIDTH_LSB           = 1;
   localparam int          WIDTH_W             = 2;
   localparam int          EXT_ADDR_BIT        = 3;
   localparam int          BASE_LSB            = 4;
   localparam int          BASE_W              = 12;
   localparam int          WINDOW_USED_W       = 16;

   // Fixed value of the unsupported extended addressing flag.
   localparam logic        EXT_ADDR_VALUE      = 1'b0;

   // Window geometry: 32-bit I/O address, window within the low 64K, 16-byte aligned block.
   localparam int          IO_ADDR_W           = 32;
   localparam int          WIN_ADDR_LSB        = 4;
   localparam int          WIN_ADDR_MSB        = 15;
   localparam int          WIN_UPPER_LSB       = 16;

   // Reset values of the writable fields and of the read-data register.
   localparam logic [1:0]  PIN_SEL_RESET       = 2'h0;
   localparam logic [11:0] BASE_RESET          = 12'h000;
   localparam logic [1:0]  WIDTH_RESET         = 2'h0;
   localparam logic        DECODE_EN_RESET     = 1'b0;
   localparam logic [31:0] RDATA_RESET         = 32'h0000_0000;

   // Card pin that carries the DMA request.
   typedef enum logic [1:0] {
      PIN_NONE   = 2'h0,
      PIN_SPKR   = 2'h1,
      PIN_IOIS16 = 2'h2,
      PIN_INPACK = 2'h3
   } req_pin_t;

   // Card-side transfer width codes; the two upper codes are reserved.
   typedef enum logic [1:0] {
      WIDTH_8    = 2'h0,
      WIDTH_16   = 2'h1,
      WIDTH_RSV2 = 2'h2,
      WIDTH_RSV3 = 2'h3
   } xfer_width_t;

   // Card pins sensed as a candidate request.
   typedef struct packed {
      logic spkr;
      logic iois16;
      logic inpack;
   } card_pins_t;

   // Writable register contents.
   typedef struct packed {
      logic [1:0]  request_pin_select;
      logic [11:0] window_base_field;
      logic [1:0]  transfer_width_field;
      logic        window_decode_enable;
   } regs_t;

   // Whole state of the register block.
   typedef struct packed {
      regs_t       regs;
      logic [31:0] rdata;
      logic        rvalid;
      logic        dma_request;
   } state_t;

endpackage : socket_dma_pkg

// ==== dma_window_decoder.sv ====
// Address comparator that claims PCI I/O accesses to the distributed DMA register window.
`timescale 1ns/1ns
`default_nettype none

module dma_window_decoder #(
   parameter int ADDR_W = 32
) (
   input  wire logic [ADDR_W-1:0] io_addr,
   input  wire logic              io_valid,
   input  wire logic [11:0]       base,
   input  wire logic              enable,
   output logic                   hit
);

   // The upper half must be zero and the low four bits are don't-care inside the 16-byte block.
   always_comb begin
      hit = io_valid && enable
            && (io_addr[ADDR_W-1:socket_dma_pkg::WIN_UPPER_LSB] == '0)                              // [R5] [R11]
            && (io_addr[socket_dma_pkg::WIN_ADDR_MSB:socket_dma_pkg::WIN_ADDR_LSB] == base);       // [R6] [R11]
   end

endmodule : dma_window_decoder
`default_nettype wire

// ==== card_pins_model.sv ====
// Behavioural model of the card side that drives the candidate request pins.
`timescale 1ns/1ns
`default_nettype none

module card_pins_model (
   input  wire logic                   clk,
   input  wire logic [2:0]             level,
   output var socket_dma_pkg::card_pins_t pins
);
   // Pins move only after a falling edge, so the block never sees them change at its sampling edge.
   initial pins = '0;
   always @(negedge clk) begin
      pins <= level;
   end
endmodule // card_pins_model

`default_nettype wire

// ==== socket_dma_config_regs_test.sv ====
// Self-checking testbench for the socket DMA configuration registers.
`timescale 1ns/1ns
`default_nettype none

module socket_dma_config_regs_test;
   logic                       clk;
   logic                       srst;
   logic                       cfg_wr;
   logic                       cfg_rd;
   logic [7:0]                 cfg_addr;
   logic [3:0]                 cfg_be;
   logic [31:0]                cfg_wdata;
   logic [31:0]                cfg_rdata;
   logic                       cfg_rvalid;
   socket_dma_pkg::card_pins_t card_pins;
   logic [2:0]                 pin_level;
   logic                       dma_request;
   logic [1:0]                 transfer_width;
   logic                       wide_transfer;
   logic [15:0]                window_base;
   logic                       decode_enabled;
   logic [31:0]                io_addr;
   logic                       io_valid;
   logic                       io_hit;
   int                         bad_count;
   int                         compares;
   int                         cycles = 0;

   socket_dma_config_regs u_dut (.clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .card_pins(card_pins), .dma_request(dma_request), .transfer_width(transfer_width),
      .wide_transfer(wide_transfer), .window_base(window_base), .decode_enabled(decode_enabled),
      .io_addr(io_addr), .io_valid(io_valid), .io_hit(io_hit));

   card_pins_model u_card (.clk(clk), .level(pin_level), .pins(card_pins));

   // Clock at 250 MHz.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // A hang is cut short well beyond the hundred or so cycles the tests need.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count = bad_count + 1;
         print_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares = compares + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // A write is taken at the one rising edge that sees the strobe.
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask

   // Read data and its valid pulse stand in the cycle after the strobe; the pulse then ends, the data holds.
   task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(negedge clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge clk);
      cfg_rd = 1'b0;
      check("cfg_rvalid", 32'h1, 32'(cfg_rvalid));
      check(what, exp, cfg_rdata);
      @(negedge clk);
      check("cfg_rvalid pulse end", 32'h0, 32'(cfg_rvalid));
   endtask

   // Write, then read at the very next edge, so the readback sees the write with no idle cycle between.
   task automatic wr_rd_check(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
      input logic [31:0] exp, input string what);
      @(negedge clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge clk);
      cfg_wr = 1'b0;
      cfg_rd = 1'b1;
      @(negedge clk);
      cfg_rd = 1'b0;
      check("cfg_rvalid", 32'h1, 32'(cfg_rvalid));
      check(what, exp, cfg_rdata);
      @(negedge clk);
      check("cfg_rvalid pulse end", 32'h0, 32'(cfg_rvalid));
   endtask

   task automatic io_probe(input logic [31:0] a, input logic v, input logic exp);
      @(negedge clk);
      io_addr = a;
      io_valid = v;
      #1;
      check("io_hit", 32'(exp), 32'(io_hit));
   endtask

   task automatic t_reset;
      read_check(8'h94, 32'h0, "pin select reset");
      read_check(8'h98, 32'h0, "window reset");
      check("transfer_width reset", 32'h0, 32'(transfer_width));
      check("decode_enabled reset", 32'h0, 32'(decode_enabled));
      io_probe(32'h0000_0000, 1'b1, 1'b0);
      $display("test reset done");
   endtask

   // Each nonzero code routes exactly one pin and code 0 routes none; the other pins held high must not leak through.
   task automatic t_pin_select;
      logic [2:0] mask;
      for (int c = 0; c < 4; c++) begin
         mask = (c == 0) ? 3'h0 : 3'(1 << (3 - c));
         wr_rd_check(8'h94, 4'hf, 32'hffff_fffc | 32'(c), 32'(c), "pin select readback");
         pin_level = 3'h7 ^ mask;
         repeat (2) @(negedge clk);
         check("dma_request other pins", 32'h0, 32'(dma_request));
         pin_level = (c == 0) ? 3'h7 : mask;
         repeat (2) @(negedge clk);
         check("dma_request selected pin", 32'(c != 0), 32'(dma_request));
      end
      pin_level = 3'h0;
      $display("test pin select done");
   endtask

   task automatic t_window;
      wr_rd_check(8'h98, 4'hf, 32'hffff_abcf, 32'h0000_abc7, "window readback");
      check("window_base", 32'h0000_abc0, 32'(window_base));
      check("decode_enabled", 32'h1, 32'(decode_enabled));
      for (int w = 0; w < 4; w++) begin
         cfg_write(8'h98, 4'hf, 32'h0000_1231 | 32'(w << 1));
         check("transfer_width", 32'(w), 32'(transfer_width));
         check("wide_transfer", 32'(w == 1), 32'(wide_transfer));
      end
      // Lane one alone moves the upper base byte; upper lanes hold only fixed bits.
      cfg_write(8'h98, 4'h2, 32'hffff_56ff);
      cfg_write(8'h98, 4'hc, 32'hffff_ffff);
      read_check(8'h98, 32'h0000_5637, "window lane write");
      $display("test window done");
   endtask

   task automatic t_decode;
      cfg_write(8'h98, 4'hf, 32'h0000_abc1);
      io_probe(32'h0000_abc0, 1'b1, 1'b1);
      io_probe(32'h0000_abcf, 1'b1, 1'b1);
      io_probe(32'h0001_abc0, 1'b1, 1'b0);
      io_probe(32'h8000_abc5, 1'b1, 1'b0);
      io_probe(32'h0000_abd0, 1'b1, 1'b0);
      io_probe(32'h0000_abbf, 1'b1, 1'b0);
      io_probe(32'h0000_abc5, 1'b0, 1'b0);
      cfg_write(8'h98, 4'hf, 32'h0000_abc0);
      io_probe(32'h0000_abc5, 1'b1, 1'b0);
      io_valid = 1'b0;
      $display("test decode done");
   endtask

   task automatic t_unmapped;
      cfg_write(8'h90, 4'hf, 32'hffff_ffff);
      read_check(8'h90, 32'h0, "unmapped read");
      read_check(8'h94, 32'h3, "pin select kept");
      read_check(8'h98, 32'h0000_abc0, "window kept");
      $display("test unmapped done");
   endtask

   // A reset in mid-run, with decode live and a request standing, must clear every field and output.
   task automatic t_mid_reset;
      cfg_write(8'h98, 4'hf, 32'h0000_abc3);
      pin_level = 3'h7;
      repeat (2) @(negedge clk);
      check("dma_request before reset", 32'h1, 32'(dma_request));
      check("wide_transfer before reset", 32'h1, 32'(wide_transfer));
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      check("dma_request after reset", 32'h0, 32'(dma_request));
      check("wide_transfer after reset", 32'h0, 32'(wide_transfer));
      check("window_base after reset", 32'h0, 32'(window_base));
      check("decode_enabled after reset", 32'h0, 32'(decode_enabled));
      io_probe(32'h0000_abc0, 1'b1, 1'b0);
      read_check(8'h94, 32'h0, "pin select after reset");
      read_check(8'h98, 32'h0, "window after reset");
      pin_level = 3'h0;
      io_valid = 1'b0;
      $display("test mid reset done");
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Reset is held for three cycles and released off the sampling edge.
   initial begin
      srst = 1'b1;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
      pin_level = 3'h0;
      io_addr = 32'h0000_0000;
      io_valid = 1'b0;
      bad_count = 0;
      compares = 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      t_reset();
      t_pin_select();
      t_window();
      t_decode();
      t_unmapped();
      t_mid_reset();
      print_verdict();
   end
endmodule // socket_dma_config_regs_test

`default_nettype wire
